//--- hdl/rfs_params.svh
// Timing counts, clock rate and counter width for the regulator fault supervisor
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH
`define RFS_CLK_HZ          10000000
`define RFS_THERM_MIN_US    100
`define RFS_THERM_CYC       ((`RFS_THERM_MIN_US * `RFS_CLK_HZ + 999999) / 1000000)
`define RFS_OC_MIN_NS       7500
`define RFS_OC_CYC          ((`RFS_OC_MIN_NS * (`RFS_CLK_HZ / 1000000) + 999) / 1000)
`define RFS_BAL_MS          1
`define RFS_BAL_CYC         ((`RFS_BAL_MS * `RFS_CLK_HZ + 999) / 1000)
`define RFS_CNT_W           14
`endif

//--- hdl/rfs_pkg.sv
// Types for the regulator fault supervisor
package rfs_pkg;
   // Comparator indications of one regulator output
   typedef struct packed {
      logic temp_warn;     // Sense at or below 640mV
      logic temp_reset;    // Sense above the 660mV reset level
      logic temp_shut;     // Sense at or below 580mV
      logic overcurrent_protect;
      logic severe_overcurrent;
      logic unbalance;     // Phase mismatch above 9mV
      logic undervolt;     // 325mV below target
      logic overvolt;      // 325mV above target
      logic below_target;
   } rfs_cmp_t;

   // Commands to the phase drivers of one output
   typedef struct packed {
      logic tristate;
      logic low_side_on;
   } rfs_drv_t;

   typedef enum logic [1:0] {
      RFS_RUN  = 2'b00,
      RFS_OVP  = 2'b01,
      RFS_OFF  = 2'b10
   } rfs_state_t;
endpackage

//--- hdl/rfs_supervisor.sv
// Fault supervisor for a dual-output regulator controller
// What this block does
// - Warning comparator drives thermal alert low
// - Warning starts thermal fault up count
// - Counter decrements while sense above warning
// - Tripped warning releases at reset level
// - Sense at 580mV forces thermal fault
// - Thermal fault: power-good low, tri-state
// - Thermal fault shuts both outputs down
// - Alert released when both above reset and both overcurrent timers at zero
// - Overvoltage: low-side on until below target
// - Enable low or POR clears faults
// - Overcurrent timer tri-states, clears if relieved
// - Severe overcurrent shuts down immediately
// - Unbalance held 1ms latches off
// - Undervoltage latches power-good low, tri-state
`timescale 1ns/10ps
`include "rfs_params.svh"
module rfs_supervisor
   import rfs_pkg::*;
#(
   parameter int THERM_CYC = `RFS_THERM_CYC,
   parameter int BAL_CYC   = `RFS_BAL_CYC,
   parameter int OC_CYC    = `RFS_OC_CYC
) (
   input  wire logic     sys_clk,
   input  wire logic     rst_b,
   input  wire logic     clk_en,
   input  wire logic     enable_in,
   input  wire logic     supply_ok,
   input  wire rfs_cmp_t cmp_in [2],
   output logic          thermal_alert_n_o,
   output logic          thermal_alert_n_oe,
   output logic [1:0]    power_good_out,
   output rfs_drv_t      drv_out [2],
   output logic [1:0]    soft_start
);
   localparam int CW = `RFS_CNT_W;

   // Counters saturate at their limit, so each limit must fit the counter
   if (THERM_CYC < 1 || THERM_CYC >= (1 << CW)) begin : g_bad_therm
      $error("rfs_supervisor: thermal count out of range");
   end
   if (BAL_CYC < 1 || BAL_CYC >= (1 << CW)) begin : g_bad_bal
      $error("rfs_supervisor: unbalance count out of range");
   end
   if (OC_CYC < 1 || OC_CYC >= (1 << CW)) begin : g_bad_oc
      $error("rfs_supervisor: overcurrent count out of range");
   end

   // Three stages; a change counts when the last two agree
   rfs_cmp_t s1_q [2];
   rfs_cmp_t s2_q [2];
   rfs_cmp_t s3_q [2];
   rfs_cmp_t c_q  [2];
   logic [2:0] en_sync_q;
   logic       en_q;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
               s1_q[g] <= '0;
               s2_q[g] <= '0;
               s3_q[g] <= '0;
               c_q[g]  <= '0;
            end else if (clk_en) begin
               s1_q[g] <= cmp_in[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               c_q[g]  <= (s2_q[g] & s3_q[g]) | (c_q[g] & (s2_q[g] | s3_q[g]));
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         en_sync_q <= 3'h0;
         en_q      <= 1'b0;
      end else if (clk_en) begin
         en_sync_q <= {en_sync_q[1:0], enable_in & supply_ok};
         if (en_sync_q[1] == en_sync_q[2])
            en_q <= en_sync_q[2];
      end
   end

   // Either output at or below the warning level
   function automatic logic any_warn(rfs_cmp_t a, rfs_cmp_t b);
      return a.temp_warn || b.temp_warn;
   endfunction

   // Warning latch with hysteresis, shared by both outputs
   // One alert pin, so release waits for both sense pins
   logic hot_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_b)
         hot_q <= 1'b0;
      else if (clk_en) begin
         if (any_warn(c_q[0], c_q[1]))
            hot_q <= 1'b1;
         else if (c_q[0].temp_reset && c_q[1].temp_reset)
            hot_q <= 1'b0;
      end
   end

   // Up/down thermal counter and per-output fault timers
   logic [CW-1:0] therm_q;
   logic [CW-1:0] oc_q  [2];
   logic [CW-1:0] bal_q [2];
   logic          therm_flt;
   logic [1:0]    oc_exp;
   logic [1:0]    bal_exp;

   always_ff @(posedge sys_clk) begin
      if (!rst_b || (clk_en && !en_q))
         therm_q <= '0;
      else if (clk_en) begin
         if (hot_q && any_warn(c_q[0], c_q[1])) begin
            if (therm_q != CW'(THERM_CYC))
               therm_q <= therm_q + 1'b1;
         end else if (therm_q != '0)
            therm_q <= therm_q - 1'b1;
      end
   end

   assign therm_flt = (therm_q == CW'(THERM_CYC)) ||
                      c_q[0].temp_shut || c_q[1].temp_shut;

   generate
      for (g = 0; g < 2; g++) begin : g_tmr
         always_ff @(posedge sys_clk) begin
            if (!rst_b || (clk_en && !en_q))
               oc_q[g] <= '0;
            else if (clk_en) begin
               if (!c_q[g].overcurrent_protect)
                  oc_q[g] <= '0;
               else if (oc_q[g] != CW'(OC_CYC))
                  oc_q[g] <= oc_q[g] + 1'b1;
            end
         end
         always_ff @(posedge sys_clk) begin
            if (!rst_b || (clk_en && !en_q))
               bal_q[g] <= '0;
            else if (clk_en) begin
               if (!c_q[g].unbalance)
                  bal_q[g] <= '0;
               else if (bal_q[g] != CW'(BAL_CYC))
                  bal_q[g] <= bal_q[g] + 1'b1;
            end
         end
         assign oc_exp[g]  = (oc_q[g] == CW'(OC_CYC));
         assign bal_exp[g] = (bal_q[g] == CW'(BAL_CYC));
      end
   endgenerate

   // Per-output state; any latched fault except overvoltage takes down both outputs
   rfs_state_t st_q [2];
   logic [1:0] off_req;
   logic [1:0] ovp_req;
   logic       any_off;

   generate
      for (g = 0; g < 2; g++) begin : g_req
         assign off_req[g] = c_q[g].severe_overcurrent || bal_exp[g] ||
                             c_q[g].undervolt;
         assign ovp_req[g] = c_q[g].overvolt;
      end
   endgenerate
   assign any_off = therm_flt || (|off_req);

   generate
      for (g = 0; g < 2; g++) begin : g_fsm
         always_ff @(posedge sys_clk) begin
            if (!rst_b || (clk_en && !en_q))
               st_q[g] <= RFS_RUN;
            else if (clk_en) begin
               case (st_q[g])
                  RFS_RUN: begin
                     if (ovp_req[g])
                        st_q[g] <= RFS_OVP;
                     else if (any_off)
                        st_q[g] <= RFS_OFF;
                  end
                  RFS_OVP: begin
                     if (c_q[g].below_target && !ovp_req[g])
                        st_q[g] <= RFS_OFF;
                  end
                  RFS_OFF: begin
                     if (ovp_req[g])
                        st_q[g] <= RFS_OVP;
                  end
                  default: st_q[g] <= RFS_OFF;
               endcase
            end
         end

         always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
               power_good_out[g]      <= 1'b0;
               drv_out[g]             <= '{tristate: 1'b1, low_side_on: 1'b0};
               soft_start[g]          <= 1'b0;
            end else if (clk_en) begin
               power_good_out[g]      <= en_q && (st_q[g] == RFS_RUN) && !any_off &&
                                         !ovp_req[g];
               drv_out[g].low_side_on <= (st_q[g] == RFS_OVP);
               drv_out[g].tristate    <= !en_q || (st_q[g] == RFS_OFF) ||
                                         (st_q[g] == RFS_RUN && oc_exp[g]);
               soft_start[g]          <= en_q && !en_sync_q[2] ? 1'b0 :
                                         (en_sync_q[2] && !en_q);
            end
         end
      end
   endgenerate

   // Open drain: enable low means pulling the pin low
   always_ff @(posedge sys_clk) begin
      if (!rst_b)
         thermal_alert_n_oe <= 1'b1;
      else if (clk_en)
         thermal_alert_n_oe <= !(hot_q || (|oc_q[0]) || (|oc_q[1]));
   end
   assign thermal_alert_n_o = 1'b0;

   // Assertions
   thermal_stop_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && en_q && therm_flt |=> st_q[0] != RFS_RUN && st_q[1] != RFS_RUN)
      else $error("thermal fault left an output running");

   alert_follow_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && hot_q |=> !thermal_alert_n_oe)
      else $error("alert not driven while hot");

   hyst_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && hot_q && !(c_q[0].temp_reset && c_q[1].temp_reset) |=> hot_q)
      else $error("warning released before reset level");

   count_down_a : assert property (@(posedge sys_clk) disable iff (!rst_b || !en_q)
      clk_en && !c_q[0].temp_warn && !c_q[1].temp_warn && therm_q != '0
      |=> therm_q == $past(therm_q) - 1'b1)
      else $error("thermal counter failed to count down");

   count_up_a : assert property (@(posedge sys_clk) disable iff (!rst_b || !en_q)
      clk_en && hot_q && any_warn(c_q[0], c_q[1]) && therm_q != CW'(THERM_CYC)
      |=> therm_q == $past(therm_q) + 1'b1)
      else $error("thermal counter failed to count up");

   shut_trip_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && en_q && c_q[1].temp_shut && st_q[1] == RFS_RUN && !ovp_req[1]
      |=> st_q[1] == RFS_OFF)
      else $error("thermal shutdown level ignored");

   pg_drop_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && therm_flt |=> !power_good_out[0] && !power_good_out[1])
      else $error("power-good high during thermal fault");

   off_drive_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && st_q[1] == RFS_OFF |=> drv_out[1].tristate && !power_good_out[1])
      else $error("latched-off output still driving");

   alert_release_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && !any_warn(c_q[0], c_q[1]) && c_q[0].temp_reset && c_q[1].temp_reset
      |=> !hot_q)
      else $error("alert held with both above reset");

   sev_oc_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && en_q && st_q[0] == RFS_RUN && c_q[0].severe_overcurrent && !ovp_req[0]
      |=> st_q[0] == RFS_OFF)
      else $error("severe overcurrent not immediate");

   bal_latch_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && en_q && bal_exp[0] && st_q[0] == RFS_RUN && !ovp_req[0]
      |=> st_q[0] == RFS_OFF)
      else $error("unbalance timeout did not latch off");

   oc_clear_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && !c_q[1].overcurrent_protect |=> oc_q[1] == '0)
      else $error("overcurrent timer not cleared");

   oc_expire_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && en_q && st_q[1] == RFS_RUN && oc_exp[1] |=> drv_out[1].tristate)
      else $error("overcurrent expiry did not tri-state");

   ovp_low_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && st_q[0] == RFS_OVP |=> drv_out[0].low_side_on && !power_good_out[0])
      else $error("overvoltage low-side drive missing");

   ovp_exit_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && en_q && st_q[1] == RFS_OVP && c_q[1].below_target && !ovp_req[1]
      |=> st_q[1] == RFS_OFF)
      else $error("overvoltage exit below target missing");

   sync_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && (s2_q[0].overvolt != s3_q[0].overvolt)
      |=> c_q[0].overvolt == $past(c_q[0].overvolt))
      else $error("comparator used before stages agree");

   // Enable low must win over any latched fault
   recover_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && !en_q |=> st_q[0] == RFS_RUN && st_q[1] == RFS_RUN)
      else $error("faults not cleared by enable low");
endmodule

//--- sim/rfs_host_model.sv
// Host processor model watching the alert pin and power-good
`timescale 1ns/10ps
module rfs_host_model
   import rfs_pkg::*;
(
   input  wire logic       alert_o,
   input  wire logic       alert_oe,
   input  wire logic [1:0] power_good,
   output logic            alert_pin,
   output logic            throttle
);
   // Board pull-up holds the line high once released
   assign alert_pin = alert_oe ? 1'b1 : alert_o;
   // Load cut back while alert low or a rail not good
   assign throttle  = ~alert_pin | ~&power_good;
endmodule

//--- sim/testbench.sv
// Self-checking bench for the regulator fault supervisor
`timescale 1ns/10ps
module testbench;
   import rfs_pkg::*;
   logic        sys_clk   = 1'b0;
   logic        rst_b     = 1'b0;
   logic        enable_in = 1'b0;
   logic        supply_ok = 1'b1;
   logic        ss_seen   = 1'b0;
   rfs_cmp_t    cmp [2];
   rfs_drv_t    drv [2];
   logic        al_o, al_oe, al_pin;
   logic [1:0]  pg, ss;
   logic [31:0] lfsr = 32'h58ae;
   logic [6:0]  exp_q [$];
   int          n_errors = 0;
   int          checked  = 0;
   int          j, k;
   int          fb [3] = '{4, 3, 2};
   event        chk_ev;

   always #50 sys_clk = ~sys_clk;

   // Small counts keep the run short
   // Thermal limit above one warning burst, below three of them
   rfs_supervisor #(.THERM_CYC(12), .BAL_CYC(16), .OC_CYC(4)) dut_u (
      .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .enable_in(enable_in),
      .supply_ok(supply_ok), .cmp_in(cmp), .thermal_alert_n_o(al_o),
      .thermal_alert_n_oe(al_oe), .power_good_out(pg), .drv_out(drv), .soft_start(ss));
   rfs_host_model host_u (.alert_o(al_o), .alert_oe(al_oe), .power_good(pg),
      .alert_pin(al_pin), .throttle());

   always @(posedge sys_clk) if (ss !== 2'h0) ss_seen <= 1'b1;

   function automatic logic [6:0] st(logic [1:0] p, logic [1:0] t, logic [1:0] l, logic a);
      return {p, t, l, a};
   endfunction
   task automatic wt(int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic cmp_v(logic [6:0] e, logic [6:0] g);
      checked++;
      if (e !== g) begin
         n_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic expect_st(logic [6:0] e);
      exp_q.push_back(e);
      wt(1);
      ->chk_ev;
   endtask
   always @(chk_ev) begin : mon
      cmp_v(exp_q.pop_front(), {pg, drv[1].tristate, drv[0].tristate,
                                drv[1].low_side_on, drv[0].low_side_on, al_pin});
   end
   // Random pick of the faulting output
   function automatic logic [31:0] lfsr_next(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic pick();
      lfsr = lfsr_next(lfsr);
      j = lfsr[0];
   endtask
   task automatic restart(logic via_supply);
      cmp[0] = 9'h080;
      cmp[1] = 9'h080;
      if (via_supply) supply_ok = 1'b0;
      else enable_in = 1'b0;
      wt(12);
      supply_ok = 1'b1;
      enable_in = 1'b1;
      ss_seen = 1'b0;
      wt(16);
      cmp_v(7'h1, {6'h0, ss_seen});
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b1));
   endtask
   task automatic conclude();
      $display("n_errors %0d checked %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      cmp[0] = 9'h080;
      cmp[1] = 9'h080;
      wt(12);
      rst_b = 1'b1;
      restart(1'b0);
      // Hysteresis: release needs both sense pins above reset
      cmp[0] = 9'h100;
      wt(8);
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b0));
      cmp[0] = 9'h000;
      wt(10);
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b0));
      cmp[0] = 9'h080;
      cmp[1] = 9'h000;
      wt(10);
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b0));
      cmp[1] = 9'h080;
      wt(10);
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b1));
      // Short warnings add up past the limit, decrement must save it
      for (k = 0; k < 3; k++) begin
         pick();
         cmp[j].temp_warn = 1'b1;
         wt(6);
         cmp[j].temp_warn = 1'b0;
         wt(14);
      end
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b1));
      pick();
      cmp[j].temp_warn = 1'b1;
      wt(25);
      expect_st(st(2'b00, 2'b11, 2'b00, 1'b0));
      restart(1'b0);
      pick();
      cmp[j] = 9'h1c0;
      wt(10);
      expect_st(st(2'b00, 2'b11, 2'b00, 1'b0));
      restart(1'b1);
      // Latched faults stay after the cause goes away
      for (k = 0; k < 3; k++) begin
         pick();
         cmp[j][fb[k]] = 1'b1;
         wt(30);
         cmp[j][fb[k]] = 1'b0;
         wt(10);
         expect_st(st(2'b00, 2'b11, 2'b00, 1'b1));
         restart(k[0]);
      end
      pick();
      cmp[j].overcurrent_protect = 1'b1;
      wt(3);
      cmp[j].overcurrent_protect = 1'b0;
      wt(12);
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b1));
      cmp[j].overcurrent_protect = 1'b1;
      wt(15);
      expect_st(st(2'b11, 2'b01 << j, 2'b00, 1'b0));
      cmp[j].overcurrent_protect = 1'b0;
      wt(12);
      expect_st(st(2'b11, 2'b00, 2'b00, 1'b1));
      pick();
      cmp[j].overvolt = 1'b1;
      wt(10);
      expect_st(st(~(2'b01 << j), 2'b00, 2'b01 << j, 1'b1));
      cmp[j].overvolt = 1'b0;
      cmp[j].below_target = 1'b1;
      wt(10);
      expect_st(st(~(2'b01 << j), 2'b01 << j, 2'b00, 1'b1));
      restart(1'b0);
      wt(2);
      conclude();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      #500000;
      n_errors++;
      conclude();
   end
endmodule
